// File: mgmt_requester.sv
// management entity model issuing get and set requests
`timescale 1ns/100ps
`default_nettype none
module mgmt_requester (
    input wire logic ref_clk,
    input wire plc_mgmt_pkg::attr_rsp_t attr_rsp,
    output var plc_mgmt_pkg::attr_req_t attr_req
);
    initial attr_req = '0;
    task automatic access(input logic wr, input logic [15:0] aid, input logic [31:0] val, input int gap,
        output plc_mgmt_pkg::attr_status_t st, output logic [31:0] rd);
        repeat (gap + 1) @(posedge ref_clk);
        attr_req <= '{valid: 1'b1, write: wr, id: aid, value: val};
        @(posedge ref_clk);
        // released fields flip so stale data can never look valid
        attr_req <= '{valid: 1'b0, write: ~wr, id: ~aid, value: ~val};
        #1;
        st = attr_rsp.status;
        rd = attr_rsp.value;
    endtask
endmodule // mgmt_requester
`default_nettype wire

// File: plc_management_attribute_bank.sv
// management attribute bank: get/set port, fixed physical constants and attribute-driven helpers
`timescale 1ns/100ps
`default_nettype none
`include "plc_mgmt_map.svh"

// Notes on behaviour
// - physical constants never change on set
// - 0x00B0 reports transmit buffer depth, 10 bits
// - 0x00B1 reports receive buffer depth, 10 bits
// - 0x00B2 reports transmit path delay, microseconds
// - 0x00B3 reports receive path delay, microseconds
// - gain floor at most 0, step at most 6
// - floor plus (steps-1) times step reaches 21
// - read-write attributes settable at any time
// - disconnected node scans search time before promoting
// - promotion requests limited per seconds window
// - contention transmit attempts set by 0x0014
// - control acknowledge wait set by 0x0015
// - abandon control packet at retry limit
// - moving average with shift-based smoothing factor
// - 0x0016 reports contention random backoff
// - 0x0017 reports channel sensing iterations
// - identifiers sixteen bits, upper half vendor
// - attributes stored no narrower than listed
module plc_management_attribute_bank #(
    parameter int TX_DEPTH = 4,
    parameter int RX_DEPTH = 4,
    parameter int TX_DELAY_US = 100,
    parameter int RX_DELAY_US = 100,
    parameter int GAIN_FLOOR_DB = 0,
    parameter int GAIN_STEP_DB = 6,
    parameter int GAIN_STEPS = 5,
    parameter int SECOND_CYCLES = `SECOND_CYCLES
) (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire plc_mgmt_pkg::attr_req_t attr_req,
    output plc_mgmt_pkg::attr_rsp_t attr_rsp,
    input wire logic disconnected,
    output logic scan_done,
    input wire logic promo_request,
    output logic promo_grant,
    output logic promo_deny,
    input wire logic ctl_sent,
    input wire logic ctl_ack,
    output logic ctl_retx,
    output logic ctl_abort,
    input wire logic sample_valid,
    input wire logic [`SAMPLE_WIDTH-1:0] sample,
    output logic [`SAMPLE_WIDTH-1:0] average,
    output logic average_valid,
    input wire logic [7:0] backoff_in,
    input wire logic [7:0] sense_in,
    output logic [7:0] beacon_limit,
    output logic [7:0] attempt_limit
);

    // the constants are checked once here so that a bad build never reports them
    generate
        if (TX_DEPTH < 0 || TX_DEPTH >= (1 << `DEPTH_WIDTH) || RX_DEPTH < 0
            || RX_DEPTH >= (1 << `DEPTH_WIDTH))
        begin : g_bad_depth
            $error("buffer depth does not fit its field");
        end
        if (TX_DELAY_US < 0 || TX_DELAY_US >= (1 << `DELAY_WIDTH) || RX_DELAY_US < 0
            || RX_DELAY_US >= (1 << `DELAY_WIDTH))
        begin : g_bad_delay
            $error("path delay does not fit its field");
        end
        if (GAIN_FLOOR_DB > 0 || GAIN_FLOOR_DB < -128 || GAIN_STEP_DB < 0
            || GAIN_STEP_DB > `GAIN_STEP_MAX)
        begin : g_bad_gain
            $error("gain floor or step out of range");
        end
        if (GAIN_STEPS < 1 || GAIN_STEPS > 255
            || GAIN_FLOOR_DB + (GAIN_STEPS - 1) * GAIN_STEP_DB < `GAIN_SPAN_MIN_DB)
        begin : g_bad_span
            $error("gain steps do not span the required range");
        end
        if (SECOND_CYCLES < 2)
        begin : g_bad_second
            $error("second length too short");
        end
    endgenerate

    localparam logic [`DEPTH_WIDTH-1:0] TX_DEPTH_V = `DEPTH_WIDTH'(TX_DEPTH);
    localparam logic [`DEPTH_WIDTH-1:0] RX_DEPTH_V = `DEPTH_WIDTH'(RX_DEPTH);
    localparam logic [`DELAY_WIDTH-1:0] TX_DELAY_V = `DELAY_WIDTH'(TX_DELAY_US);
    localparam logic [`DELAY_WIDTH-1:0] RX_DELAY_V = `DELAY_WIDTH'(RX_DELAY_US);
    localparam logic [7:0] GAIN_FLOOR_V = 8'(GAIN_FLOOR_DB);
    localparam logic [`STEP_WIDTH-1:0] GAIN_STEP_V = `STEP_WIDTH'(GAIN_STEP_DB);
    localparam logic [7:0] GAIN_STEPS_V = 8'(GAIN_STEPS);
    localparam logic [31:0] SECOND_LAST = 32'(SECOND_CYCLES - 1);

    localparam plc_mgmt_pkg::rw_attrs_t ATTR_RESET = '{
        search: `RST_SWITCH_SEARCH,
        promo_lim: `RST_PROMO_LIMIT,
        promo_win: `RST_PROMO_WINDOW,
        beacons: `RST_BEACON_SLOTS,
        attempts: `RST_TX_ATTEMPTS,
        ack_to: `RST_ACK_TIMEOUT,
        retry_lim: `RST_RETRY_LIMIT,
        shift: `RST_SMOOTHING
    };

    plc_mgmt_pkg::bank_state_t st;
    plc_mgmt_pkg::bank_state_t next_st;

    function automatic logic in_range(
        input logic [`VALUE_WIDTH-1:0] v,
        input logic [`VALUE_WIDTH-1:0] lo,
        input logic [`VALUE_WIDTH-1:0] hi
    );
        in_range = (v >= lo) && (v <= hi);
    endfunction

    always_comb
    begin
        logic known;
        logic writable;
        logic [`VALUE_WIDTH-1:0] rd;
        logic [`VALUE_WIDTH-1:0] lo;
        logic [`VALUE_WIDTH-1:0] hi;
        logic [7:0] used;
        logic [7:0] wv;
        logic signed [`SAMPLE_WIDTH+1:0] diff;
        logic signed [`SAMPLE_WIDTH+1:0] step;
        logic [`SAMPLE_WIDTH+1:0] sum;
        known = 1'b1;
        writable = 1'b0;
        rd = '0;
        lo = '0;
        hi = '0;
        used = 8'h00;
        wv = attr_req.value[7:0];
        diff = '0;
        step = '0;
        sum = '0;
        next_st = st;
        next_st.rsp.valid = 1'b0;
        next_st.sec_tick = 1'b0;
        next_st.promo_grant = 1'b0;
        next_st.promo_deny = 1'b0;
        next_st.ctl_retx = 1'b0;
        next_st.ctl_abort = 1'b0;
        next_st.avg_valid = 1'b0;

        // free-running one-second tick shared by every seconds timer
        if (st.sec_cnt == SECOND_LAST)
        begin
            next_st.sec_cnt = 32'h0000_0000;
            next_st.sec_tick = 1'b1;
        end
        else
        begin
            next_st.sec_cnt = st.sec_cnt + 32'h0000_0001;
        end

        // the first tick after entry may come at once, so one extra tick keeps the scan a least time
        if (!disconnected)
        begin
            next_st.scan_sec = 8'h00;
            next_st.scan_done = 1'b0;
        end
        else if (st.scan_sec > st.attr.search)
        begin
            next_st.scan_done = 1'b1;
        end
        else if (st.sec_tick)
        begin
            next_st.scan_sec = st.scan_sec + 8'h01;
        end

        // promotion budget: a window roll and a request in one cycle see the fresh window
        used = st.win_used;
        if (st.sec_tick)
        begin
            if (st.win_sec + 8'h01 >= st.attr.promo_win)
            begin
                next_st.win_sec = 8'h00;
                used = 8'h00;
            end
            else
            begin
                next_st.win_sec = st.win_sec + 8'h01;
            end
        end
        if (promo_request)
        begin
            if (used < st.attr.promo_lim)
            begin
                next_st.promo_grant = 1'b1;
                used = used + 8'h01;
            end
            else
            begin
                next_st.promo_deny = 1'b1;
            end
        end
        next_st.win_used = used;

        // control packet acknowledge wait and retransmission count
        if (ctl_ack)
        begin
            next_st.ctl_busy = 1'b0;
        end
        else if (ctl_sent)
        begin
            next_st.ctl_busy = 1'b1;
            next_st.ctl_sec = 8'h00;
            next_st.ctl_retries = 8'h00;
        end
        else if (st.ctl_busy && st.sec_tick)
        begin
            if (st.ctl_sec >= st.attr.ack_to)
            begin
                next_st.ctl_sec = 8'h00;
                if (st.ctl_retries >= st.attr.retry_lim)
                begin
                    next_st.ctl_abort = 1'b1;
                    next_st.ctl_busy = 1'b0;
                end
                else
                begin
                    next_st.ctl_retx = 1'b1;
                    next_st.ctl_retries = st.ctl_retries + 8'h01;
                end
            end
            else
            begin
                next_st.ctl_sec = st.ctl_sec + 8'h01;
            end
        end

        // the first sample seeds the average so it does not creep up from zero
        if (sample_valid)
        begin
            next_st.avg_valid = 1'b1;
            if (!st.avg_seeded)
            begin
                next_st.avg = sample;
                next_st.avg_seeded = 1'b1;
            end
            else
            begin
                diff = $signed({2'b00, sample}) - $signed({2'b00, st.avg});
                step = diff >>> st.attr.shift[2:0];
                sum = {2'b00, st.avg} + step;
                next_st.avg = sum[`SAMPLE_WIDTH-1:0];
            end
        end

        // identifier decode: value read, whether settable, and its legal range
        case (attr_req.id)
            `ID_SWITCH_SEARCH:
            begin
                rd = 32'(st.attr.search);
                writable = 1'b1;
                lo = `MIN_SWITCH_SEARCH;
                hi = `MAX_SWITCH_SEARCH;
            end
            `ID_PROMO_LIMIT:
            begin
                rd = 32'(st.attr.promo_lim);
                writable = 1'b1;
                lo = `MIN_PROMO_LIMIT;
                hi = `MAX_PROMO_LIMIT;
            end
            `ID_PROMO_WINDOW:
            begin
                rd = 32'(st.attr.promo_win);
                writable = 1'b1;
                lo = `MIN_PROMO_WINDOW;
                hi = `MAX_PROMO_WINDOW;
            end
            `ID_BEACON_SLOTS:
            begin
                rd = 32'(st.attr.beacons);
                writable = 1'b1;
                lo = `MIN_BEACON_SLOTS;
                hi = `MAX_BEACON_SLOTS;
            end
            `ID_TX_ATTEMPTS:
            begin
                rd = 32'(st.attr.attempts);
                writable = 1'b1;
                lo = `MIN_TX_ATTEMPTS;
                hi = `MAX_TX_ATTEMPTS;
            end
            `ID_ACK_TIMEOUT:
            begin
                rd = 32'(st.attr.ack_to);
                writable = 1'b1;
                lo = `MIN_ACK_TIMEOUT;
                hi = `MAX_ACK_TIMEOUT;
            end
            `ID_RETRY_LIMIT:
            begin
                rd = 32'(st.attr.retry_lim);
                writable = 1'b1;
                lo = `MIN_RETRY_LIMIT;
                hi = `MAX_RETRY_LIMIT;
            end
            `ID_SMOOTHING:
            begin
                rd = 32'(st.attr.shift);
                writable = 1'b1;
                lo = `MIN_SMOOTHING;
                hi = `MAX_SMOOTHING;
            end
            `ID_BACKOFF: rd = 32'(backoff_in);
            `ID_SENSE_ITER: rd = 32'(sense_in);
            `ID_TX_DEPTH: rd = 32'(TX_DEPTH_V);
            `ID_RX_DEPTH: rd = 32'(RX_DEPTH_V);
            `ID_TX_DELAY: rd = 32'(TX_DELAY_V);
            `ID_RX_DELAY: rd = 32'(RX_DELAY_V);
            `ID_GAIN_FLOOR: rd = 32'(GAIN_FLOOR_V);
            `ID_GAIN_STEP: rd = 32'(GAIN_STEP_V);
            `ID_GAIN_TOTAL: rd = 32'(GAIN_STEPS_V);
            default: known = 1'b0;
        endcase

        if (attr_req.valid)
        begin
            next_st.rsp.valid = 1'b1;
            next_st.rsp.value = '0;
            next_st.rsp.status = plc_mgmt_pkg::ST_OK;
            if (!known)
            begin
                next_st.rsp.status = plc_mgmt_pkg::ST_UNKNOWN;
            end
            else if (!attr_req.write)
            begin
                next_st.rsp.value = rd;
            end
            else if (!writable)
            begin
                next_st.rsp.status = plc_mgmt_pkg::ST_READ_ONLY;
            end
            else if (!in_range(attr_req.value, lo, hi))
            begin
                next_st.rsp.status = plc_mgmt_pkg::ST_RANGE;
            end
            else
            begin
                // a set is honoured at any time, whatever the helpers are doing
                case (attr_req.id)
                    `ID_SWITCH_SEARCH: next_st.attr.search = wv;
                    `ID_PROMO_LIMIT: next_st.attr.promo_lim = wv;
                    `ID_PROMO_WINDOW: next_st.attr.promo_win = wv;
                    `ID_BEACON_SLOTS: next_st.attr.beacons = wv;
                    `ID_TX_ATTEMPTS: next_st.attr.attempts = wv;
                    `ID_ACK_TIMEOUT: next_st.attr.ack_to = wv;
                    `ID_RETRY_LIMIT: next_st.attr.retry_lim = wv;
                    `ID_SMOOTHING: next_st.attr.shift = wv;
                    default: next_st.attr = st.attr;
                endcase
            end
        end
    end

    always_ff @(posedge ref_clk or negedge resetn)
    begin
        if (!resetn)
        begin
            st <= '0;
            st.rsp.status <= plc_mgmt_pkg::ST_OK;
            st.attr <= ATTR_RESET;
        end
        else
        begin
            st <= next_st;
        end
    end

    // every output below is a field of the state register
    assign attr_rsp = st.rsp;
    assign scan_done = st.scan_done;
    assign promo_grant = st.promo_grant;
    assign promo_deny = st.promo_deny;
    assign ctl_retx = st.ctl_retx;
    assign ctl_abort = st.ctl_abort;
    assign average = st.avg;
    assign average_valid = st.avg_valid;
    assign beacon_limit = st.attr.beacons;
    assign attempt_limit = st.attr.attempts;

endmodule // plc_management_attribute_bank
`default_nettype wire

// File: plc_mgmt_bank_properties.sv
// concurrent checks on the attribute bank ports
`timescale 1ns/100ps
`default_nettype none
`include "plc_mgmt_map.svh"
module plc_mgmt_bank_properties (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire plc_mgmt_pkg::attr_req_t attr_req,
    input wire plc_mgmt_pkg::attr_rsp_t attr_rsp,
    input wire logic disconnected,
    input wire logic scan_done,
    input wire logic promo_request,
    input wire logic promo_grant,
    input wire logic promo_deny,
    input wire logic ctl_retx,
    input wire logic ctl_abort,
    input wire logic sample_valid,
    input wire logic average_valid,
    input wire logic [7:0] beacon_limit,
    input wire logic [7:0] attempt_limit
);
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!resetn);
    chk_rsp_follows: assert property (attr_req.valid |=> attr_rsp.valid)
        else $error("answer missing after request");
    chk_rsp_quiet: assert property (!attr_req.valid |=> !attr_rsp.valid)
        else $error("answer without request");
    chk_phy_locked: assert property (attr_req.valid && attr_req.write && attr_req.id inside {[16'h00B0:16'h00B6]}
        |=> attr_rsp.status == plc_mgmt_pkg::ST_READ_ONLY)
        else $error("set of physical constant not refused");
    chk_vendor_unknown: assert property (attr_req.valid && attr_req.id[15]
        |=> attr_rsp.status == plc_mgmt_pkg::ST_UNKNOWN)
        else $error("vendor identifier not reported unknown");
    chk_range_reject: assert property (attr_req.valid && attr_req.write && attr_req.id == 16'h0013
        && (attr_req.value == 32'h0 || attr_req.value > 32'h5) |=> attr_rsp.status == plc_mgmt_pkg::ST_RANGE)
        else $error("beacon slot value out of range accepted");
    chk_promo_answer: assert property (promo_request |=> promo_grant != promo_deny)
        else $error("promotion request not answered once");
    chk_beacon_bounds: assert property (beacon_limit inside {[8'h01:8'h05]})
        else $error("beacon limit outside one to five");
    chk_attempt_bounds: assert property (attempt_limit inside {[8'h02:8'h05]})
        else $error("attempt limit outside two to five");
    chk_retry_exclusive: assert property (!(ctl_retx && ctl_abort))
        else $error("retransmit and abandon together");
    chk_avg_strobe: assert property (sample_valid |=> average_valid)
        else $error("average not updated after sample");
    chk_scan_drop: assert property (!disconnected |=> !scan_done)
        else $error("scan done while connected");
endmodule // plc_mgmt_bank_properties
bind plc_management_attribute_bank plc_mgmt_bank_properties i_plc_mgmt_bank_properties (
    .ref_clk(ref_clk), .resetn(resetn), .attr_req(attr_req), .attr_rsp(attr_rsp),
    .disconnected(disconnected), .scan_done(scan_done), .promo_request(promo_request),
    .promo_grant(promo_grant), .promo_deny(promo_deny), .ctl_retx(ctl_retx), .ctl_abort(ctl_abort),
    .sample_valid(sample_valid), .average_valid(average_valid), .beacon_limit(beacon_limit),
    .attempt_limit(attempt_limit)
);
`default_nettype wire

// File: plc_mgmt_map.svh
// offsets, field widths, defaults, ranges and timing constants of the attribute bank
`ifndef PLC_MGMT_MAP_SVH
`define PLC_MGMT_MAP_SVH

`define ID_WIDTH 16
`define VALUE_WIDTH 32
`define ATTR_WIDTH 8
`define VENDOR_ID_BASE 16'h8000

`define ID_SWITCH_SEARCH 16'h0010
`define ID_PROMO_LIMIT 16'h0011
`define ID_PROMO_WINDOW 16'h0012
`define ID_BEACON_SLOTS 16'h0013
`define ID_TX_ATTEMPTS 16'h0014
`define ID_ACK_TIMEOUT 16'h0015
`define ID_BACKOFF 16'h0016
`define ID_SENSE_ITER 16'h0017
`define ID_RETRY_LIMIT 16'h0018
`define ID_SMOOTHING 16'h0019
`define ID_TX_DEPTH 16'h00B0
`define ID_RX_DEPTH 16'h00B1
`define ID_TX_DELAY 16'h00B2
`define ID_RX_DELAY 16'h00B3
`define ID_GAIN_FLOOR 16'h00B4
`define ID_GAIN_STEP 16'h00B5
`define ID_GAIN_TOTAL 16'h00B6

`define DEPTH_WIDTH 10
`define DELAY_WIDTH 20
`define STEP_WIDTH 3
`define GAIN_STEP_MAX 6
`define GAIN_SPAN_MIN_DB 21

`define RST_SWITCH_SEARCH 8'h18
`define RST_PROMO_LIMIT 8'h02
`define RST_PROMO_WINDOW 8'h05
`define RST_BEACON_SLOTS 8'h05
`define RST_TX_ATTEMPTS 8'h05
`define RST_ACK_TIMEOUT 8'h0F
`define RST_RETRY_LIMIT 8'h03
`define RST_SMOOTHING 8'h03

`define MIN_SWITCH_SEARCH 32'h10
`define MAX_SWITCH_SEARCH 32'h20
`define MIN_PROMO_LIMIT 32'h1
`define MAX_PROMO_LIMIT 32'h4
`define MIN_PROMO_WINDOW 32'h2
`define MAX_PROMO_WINDOW 32'h8
`define MIN_BEACON_SLOTS 32'h1
`define MAX_BEACON_SLOTS 32'h5
`define MIN_TX_ATTEMPTS 32'h2
`define MAX_TX_ATTEMPTS 32'h5
`define MIN_ACK_TIMEOUT 32'h2
`define MAX_ACK_TIMEOUT 32'h14
`define MIN_RETRY_LIMIT 32'h3
`define MAX_RETRY_LIMIT 32'h5
`define MIN_SMOOTHING 32'h0
`define MAX_SMOOTHING 32'h7

`define CLK_PERIOD_NS 5
`define SECOND_NS 1000000000
`define SECOND_CYCLES (`SECOND_NS / `CLK_PERIOD_NS)
`define SAMPLE_WIDTH 16

`endif

// File: plc_mgmt_pkg.sv
// types shared by the management attribute bank
`default_nettype none
`include "plc_mgmt_map.svh"
package plc_mgmt_pkg;

    typedef enum logic [1:0] {ST_OK, ST_UNKNOWN, ST_READ_ONLY, ST_RANGE} attr_status_t;

    typedef struct packed {
        logic valid;
        logic write;
        logic [`ID_WIDTH-1:0] id;
        logic [`VALUE_WIDTH-1:0] value;
    } attr_req_t;

    typedef struct packed {
        logic valid;
        attr_status_t status;
        logic [`VALUE_WIDTH-1:0] value;
    } attr_rsp_t;

    typedef struct packed {
        logic [7:0] search;
        logic [7:0] promo_lim;
        logic [7:0] promo_win;
        logic [7:0] beacons;
        logic [7:0] attempts;
        logic [7:0] ack_to;
        logic [7:0] retry_lim;
        logic [7:0] shift;
    } rw_attrs_t;

    typedef struct packed {
        attr_rsp_t rsp;
        rw_attrs_t attr;
        logic [31:0] sec_cnt;
        logic sec_tick;
        logic [7:0] scan_sec;
        logic scan_done;
        logic [7:0] win_sec;
        logic [7:0] win_used;
        logic promo_grant;
        logic promo_deny;
        logic ctl_busy;
        logic [7:0] ctl_sec;
        logic [7:0] ctl_retries;
        logic ctl_retx;
        logic ctl_abort;
        logic [`SAMPLE_WIDTH-1:0] avg;
        logic avg_seeded;
        logic avg_valid;
    } bank_state_t;

endpackage
`default_nettype wire

// File: tb.sv
// self-checking bench for the management attribute bank
`timescale 1ns/100ps
`default_nettype none
module tb;
    localparam int SC = 20;
    localparam logic [15:0] IDS [8] = '{16'h10, 16'h11, 16'h12, 16'h13, 16'h14, 16'h15, 16'h18, 16'h19};
    localparam logic [31:0] DEF [8] = '{32'h18, 32'h2, 32'h5, 32'h5, 32'h5, 32'hF, 32'h3, 32'h3};
    localparam logic [31:0] LO [8] = '{32'h10, 32'h1, 32'h2, 32'h1, 32'h2, 32'h2, 32'h3, 32'h0};
    localparam logic [31:0] HI [8] = '{32'h20, 32'h4, 32'h8, 32'h5, 32'h5, 32'h14, 32'h5, 32'h7};
    localparam logic [31:0] PHY [7] = '{32'h258, 32'h25, 32'hAAE60, 32'h3039, 32'hFD, 32'h6, 32'h5};
    localparam logic [15:0] UNK [4] = '{16'h1F, 16'hB7, 16'h8000, 16'hFFFF};
    logic ref_clk = 1'b0, resetn = 1'b0, disconnected = 1'b0, promo_request = 1'b0;
    logic ctl_sent = 1'b0, ctl_ack = 1'b0, sample_valid = 1'b0;
    logic [15:0] sample = 16'h0, average, exp_avg;
    logic [7:0] backoff_in = 8'h0, sense_in = 8'h0, beacon_limit, attempt_limit;
    logic scan_done, promo_grant, promo_deny, ctl_retx, ctl_abort, average_valid;
    plc_mgmt_pkg::attr_req_t attr_req;
    plc_mgmt_pkg::attr_rsp_t attr_rsp;
    plc_mgmt_pkg::attr_status_t st;
    logic [31:0] rd, v;
    logic [31:0] cur [8];
    int num_errors = 0, comparisons = 0, n, g;
    always #2.5 ref_clk = ~ref_clk;
    plc_management_attribute_bank #(.TX_DEPTH(600), .RX_DEPTH(37), .TX_DELAY_US(700000), .RX_DELAY_US(12345),
        .GAIN_FLOOR_DB(-3), .GAIN_STEP_DB(6), .GAIN_STEPS(5), .SECOND_CYCLES(SC)) i_plc_management_attribute_bank (
        .ref_clk(ref_clk), .resetn(resetn), .attr_req(attr_req), .attr_rsp(attr_rsp),
        .disconnected(disconnected), .scan_done(scan_done), .promo_request(promo_request),
        .promo_grant(promo_grant), .promo_deny(promo_deny), .ctl_sent(ctl_sent), .ctl_ack(ctl_ack),
        .ctl_retx(ctl_retx), .ctl_abort(ctl_abort), .sample_valid(sample_valid), .sample(sample),
        .average(average), .average_valid(average_valid), .backoff_in(backoff_in), .sense_in(sense_in),
        .beacon_limit(beacon_limit), .attempt_limit(attempt_limit));
    mgmt_requester i_mgmt_requester (.ref_clk(ref_clk), .attr_rsp(attr_rsp), .attr_req(attr_req));
    task automatic end_of_test();
        $display("comparisons %0d mismatches %0d", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic check_value(input logic [31:0] got, input logic [31:0] exp, input string what);
        comparisons++;
        if (got !== exp)
        begin
            num_errors++;
            $display("BAD %0t %s got %h expected %h", $time, what, got, exp);
        end
    endtask
    task automatic check_status(input plc_mgmt_pkg::attr_status_t got, input plc_mgmt_pkg::attr_status_t exp);
        check_value({30'h0, got}, {30'h0, exp}, "status");
    endtask
    task automatic acc(input logic wr, input logic [15:0] aid, input logic [31:0] val);
        i_mgmt_requester.access(wr, aid, val, $urandom_range(2), st, rd);
    endtask
    task automatic step();
        @(posedge ref_clk);
        #1;
        n++;
        if (n > 30 * SC)
        begin
            num_errors++;
            $display("BAD %0t wait ran out", $time);
            end_of_test();
        end
    endtask
    task automatic check_defaults();
        for (int i = 0; i < 8; i++)
        begin
            acc(1'b0, IDS[i], 32'h0);
            check_value(rd, DEF[i], "default");
        end
        check_value({beacon_limit, attempt_limit}, 32'h0505, "limits at reset");
        $display("defaults test done");
    endtask
    // floor division by the power of two, as the smoothing shift asks
    function automatic logic [15:0] ema(input logic [15:0] a, input logic [15:0] s, input logic [31:0] sh);
        logic signed [17:0] d;
        d = $signed({2'b00, s}) - $signed({2'b00, a});
        return a + 16'(d >>> sh);
    endfunction
    initial
    begin
        void'($urandom(11673));
        repeat (10) @(posedge ref_clk);
        resetn <= 1'b1;
        check_defaults();
        for (int i = 0; i < 7; i++)
        begin
            acc(1'b1, 16'hB0 + 16'(i), $urandom);
            check_status(st, plc_mgmt_pkg::ST_READ_ONLY);
            acc(1'b0, 16'hB0 + 16'(i), 32'h0);
            check_value(rd, PHY[i], "phy constant");
        end
        backoff_in <= 8'($urandom_range(15, 1));
        sense_in <= 8'($urandom_range(5, 2));
        acc(1'b1, 16'h16, 32'h3);
        check_status(st, plc_mgmt_pkg::ST_READ_ONLY);
        acc(1'b0, 16'h16, 32'h0);
        check_value(rd, {24'h0, backoff_in}, "backoff");
        acc(1'b0, 16'h17, 32'h0);
        check_value(rd, {24'h0, sense_in}, "sense count");
        foreach (UNK[i])
        begin
            acc(i[0], UNK[i], 32'h1);
            check_status(st, plc_mgmt_pkg::ST_UNKNOWN);
        end
        $display("fixed attribute test done");
        for (int i = 0; i < 8; i++)
        begin
            acc(1'b1, IDS[i], LO[i] - 32'h1);
            check_status(st, plc_mgmt_pkg::ST_RANGE);
            acc(1'b1, IDS[i], HI[i] + 32'h1);
            check_status(st, plc_mgmt_pkg::ST_RANGE);
            acc(1'b0, IDS[i], 32'h0);
            check_value(rd, DEF[i], "kept");
            cur[i] = $urandom_range(HI[i], LO[i]);
            acc(1'b1, IDS[i], cur[i]);
            check_status(st, plc_mgmt_pkg::ST_OK);
            acc(1'b0, IDS[i], 32'h0);
            check_value(rd, cur[i], "readback");
        end
        check_value({beacon_limit, attempt_limit}, {16'h0, cur[3][7:0], cur[4][7:0]}, "limits");
        $display("read-write test done");
        g = 0;
        n = 0;
        for (int c = 0; c < 10; c++)
        begin
            @(posedge ref_clk);
            promo_request <= (c < 6);
            #1;
            g += promo_grant;
            n += promo_deny;
        end
        check_value(32'(g + n), 32'h6, "promotion answers");
        check_value(32'(g >= cur[1] && g <= 2 * cur[1]), 32'h1, "promotion grants");
        acc(1'b1, 16'h10, 32'h10);
        @(posedge ref_clk);
        disconnected <= 1'b1;
        n = 0;
        while (scan_done !== 1'b1)
            step();
        check_value(32'(n >= 16 * SC && n <= 18 * SC), 32'h1, "scan time");
        disconnected <= 1'b0;
        repeat (2) @(posedge ref_clk);
        #1;
        check_value({31'h0, scan_done}, 32'h0, "scan cleared");
        $display("promotion test done");
        acc(1'b1, 16'h15, 32'h2);
        acc(1'b1, 16'h18, 32'h3);
        @(posedge ref_clk);
        ctl_sent <= 1'b1;
        @(posedge ref_clk);
        ctl_sent <= 1'b0;
        g = 0;
        n = 0;
        while (ctl_abort !== 1'b1)
        begin
            step();
            g += ctl_retx;
        end
        check_value(32'(g), 32'h3, "retransmits");
        check_value(32'(n >= 8 * SC && n <= 13 * SC), 32'h1, "ack wait");
        @(posedge ref_clk);
        ctl_sent <= 1'b1;
        @(posedge ref_clk);
        ctl_sent <= 1'b0;
        repeat (SC) @(posedge ref_clk);
        ctl_ack <= 1'b1;
        @(posedge ref_clk);
        ctl_ack <= 1'b0;
        g = 0;
        n = 0;
        repeat (5 * SC)
        begin
            step();
            g += ctl_retx + ctl_abort;
        end
        check_value(32'(g), 32'h0, "acknowledged packet");
        $display("control test done");
        v = $urandom_range(7);
        acc(1'b1, 16'h19, v);
        for (int k = 0; k < 24; k++)
        begin
            @(posedge ref_clk);
            sample_valid <= 1'b1;
            sample <= (k == 5) ? 16'hFFFF : (k == 6) ? 16'h0 : 16'($urandom);
            @(posedge ref_clk);
            sample_valid <= 1'b0;
            #1;
            exp_avg = (k == 0) ? sample : ema(exp_avg, sample, v);
            check_value({15'h0, average_valid, average}, {16'h1, exp_avg}, "average");
        end
        $display("average test done");
        resetn <= 1'b0;
        repeat (3) @(posedge ref_clk);
        resetn <= 1'b1;
        check_defaults();
        end_of_test();
    end
endmodule // tb
`default_nettype wire
